/* verilog/ttu_pkg.sv */
// constants, field layout and encodings of the triple timer/counter unit
package ttu_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_FIRST_CNT = 8'h04;
	localparam logic [7:0] A_SECOND_CNT = 8'h08;
	localparam logic [7:0] A_FIRST_REL = 8'h0c;
	localparam logic [7:0] A_SECOND_REL = 8'h10;
	localparam logic [7:0] A_T3_CTRL = 8'h14;
	localparam logic [7:0] A_T3_EVT = 8'h18;
	localparam logic [7:0] A_T3_CNT = 8'h1c;
	localparam logic [7:0] A_T3_REG0 = 8'h20;
	localparam logic [7:0] A_T3_REG1 = 8'h24;
	localparam logic [7:0] A_OUT_SEL = 8'h28;
	localparam logic [7:0] A_SR_MASK01 = 8'h2c;
	localparam logic [7:0] A_SR_MASK23 = 8'h30;
	localparam logic [7:0] A_STATUS = 8'h34;
	localparam logic [31:0] RST_VAL = 32'h0000_0000;
	localparam logic [31:0] ALL_ONES = 32'hffff_ffff;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] BYTE_MAX = 8'hff;
	localparam logic [15:0] HALF_ZERO = 16'h0000;
	localparam logic [15:0] HALF_MAX = 16'hffff;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// common control word
	localparam int RUN0 = 0;
	localparam int RUN1 = 1;
	localparam int CHAIN_LO = 2;
	localparam int SRC0_LO = 9;
	localparam int SRC1_LO = 11;
	// third timer control word
	localparam int T3_RUN = 0;
	localparam int MODE_LO = 1;
	localparam int DIR_DOWN = 3;
	localparam int DIR_EXT = 4;
	localparam int ONE_SHOT = 5;
	localparam int SPLIT = 6;
	localparam int REG0_CAP = 7;
	localparam int REG1_CAP = 8;
	localparam int CAP_CLR = 9;
	localparam int DIRSEL_LO = 10;
	localparam int HISRC_LO = 13;
	// third timer event word: 5-bit fields, source low, edge high
	localparam int EV_CNT_LO = 0;
	localparam int EV_REL_LO = 5;
	localparam int EV_CAP_LO = 10;
	localparam int EV_START_LO = 15;
	localparam int EV_STOP_LO = 20;
	localparam int EV_CLR_LO = 25;
	localparam int EVF_W = 5;
	localparam int SEL_W = 4;
	localparam int SR_STRIDE = 16;
	localparam int N_EV = 12;
	localparam int N_SR = 4;
	localparam int N_OUT = 4;
	localparam int N_IN = 8;
	localparam int ST_OUT_LO = 4;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	localparam int PIN_QA = 0;
	localparam int PIN_QB = 1;
	localparam int PIN_CLK0 = 2;
	localparam int PIN_GATE0 = 3;
	localparam int PIN_CLK1 = 4;
	localparam int PIN_GATE1 = 5;
	typedef enum logic [1:0] {MD_TIMER, MD_COUNT, MD_QUAD} ttu_mode_t;
	typedef enum logic [1:0] {CS_CLK, CS_PIN, CS_T3, CS_GATE} ttu_csrc_t;
endpackage

/* verilog/ttu_slice.sv */
// one 8-bit counting slice of the first or second timer
`timescale 1ns/1ps
module ttu_slice (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic tick,
	input wire logic load,
	input wire logic [7:0] load_val,
	input wire logic [7:0] reload_val,
	output logic [7:0] cnt,
	output logic carry
);
	assign carry = tick & (cnt == ttu_pkg::BYTE_MAX);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt <= ttu_pkg::BYTE_ZERO;
		end else if (load) begin
			cnt <= load_val;
		end else if (carry) begin
			cnt <= reload_val;
		end else if (tick) begin
			cnt <= cnt + 8'h01;
		end
	end
endmodule

/* verilog/ttu_top.sv */
// triple timer/counter unit with an AXI4-Lite register slave
// Summary of operation
// - three independent 32-bit timers for timing, counting and recording
// - every timer can count once per module clock
// - first/second timer events can trigger third timer actions
// - third timer wrap can clock the first or second timer
// - first and second timers chain into one 64-bit counter
// - first/second timers reload automatically from own register on overflow
// - first/second timers split into 8, 16 or 24-bit parts
// - first/second overflows feed service requests, pins and third timer
// - a control field chooses the count option of first/second timer; a clock pin and a gate pin feed it
// - third timer runs as timer, counter or quadrature decoder
// - third timer counts up or down, by software or pin
// - third timer has pin start/stop, one-shot and pin clear
// - third timer has two 32-bit reload-or-capture registers
// - third timer reloads on overflow or underflow
// - third timer reloads on rising, falling or either pin edge
// - third timer captures count on rising, falling or both edges
// - third timer can capture then clear on a chosen edge
// - third timer splits into two independent 16-bit counters
// - pins and first/second overflows drive third timer functions
// - third timer wraps trigger first/second timer and toggle pins
// - every event routes freely to any service request node
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
module ttu_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [7:0] in_pin,
	output logic [3:0] out_pin,
	output logic [3:0] srq
);
	logic aw_got, w_got, do_wr, wr_ok;
	logic [7:0] aw_addr;
	logic [31:0] w_data, rd_val;
	logic [3:0] w_strb;
	logic [31:0] ctrl, first_rel, second_rel, t3ctrl, t3evt;
	logic [31:0] t3cnt, reg0, reg1, outsel, srm01, srm23;
	logic [7:0] pin_d, rise, fall;
	logic [63:0] cnt_all, ld_val, rel_all;
	logic [7:0] carry, tick_v, load_v, slice_ovf;
	logic tick0, tick1, t3wrap_q;
	logic [ttu_pkg::N_EV-1:0] ev;
	logic [15:0] ev16;
	logic run3, up, qdir, cnt_ev, hi_ev, tick_lo, tick_hi;
	logic lo_wrap, hi_wrap, t3_ovf, t3_unf, split;
	logic ev_rel, ev_cap, ev_start, ev_stop, ev_clr, plain;
	logic [15:0] next_lo, next_hi;
	ttu_pkg::ttu_mode_t mode;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[8*i +: 8] = d[8*i +: 8];
			end
		end
		return r;
	endfunction

	// an event field: source index in the low bits, edge choice above
	function automatic logic pick(input logic [4:0] f,
		input logic [7:0] r, input logic [7:0] fl);
		logic e;
		case (f[4:3])
			ttu_pkg::EDGE_RISE: e = r[f[2:0]];
			ttu_pkg::EDGE_FALL: e = fl[f[2:0]];
			ttu_pkg::EDGE_BOTH: e = r[f[2:0]] | fl[f[2:0]];
			default: e = 1'b0;
		endcase
		return e;
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		return a[1:0] == 2'h0 && a <= ttu_pkg::A_STATUS;
	endfunction

	// write channel: address and data are taken in either order
	assign do_wr = aw_got & w_got & ~s_axi_bvalid;
	assign wr_ok = do_wr & mapped(aw_addr) & (aw_addr != ttu_pkg::A_STATUS);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_addr <= ttu_pkg::BYTE_ZERO;
			w_data <= ttu_pkg::RST_VAL;
			w_strb <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= ttu_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid & s_axi_awready) begin
				aw_got <= 1'b1;
				aw_addr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_got <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_wr) begin
				aw_got <= 1'b0;
				w_got <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? ttu_pkg::RESP_OKAY :
					ttu_pkg::RESP_SLVERR;
			end
			if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always_comb begin
		case (s_axi_araddr)
			ttu_pkg::A_CTRL: rd_val = ctrl;
			ttu_pkg::A_FIRST_CNT: rd_val = cnt_all[31:0];
			ttu_pkg::A_SECOND_CNT: rd_val = cnt_all[63:32];
			ttu_pkg::A_FIRST_REL: rd_val = first_rel;
			ttu_pkg::A_SECOND_REL: rd_val = second_rel;
			ttu_pkg::A_T3_CTRL: rd_val = t3ctrl;
			ttu_pkg::A_T3_EVT: rd_val = t3evt;
			ttu_pkg::A_T3_CNT: rd_val = t3cnt;
			ttu_pkg::A_T3_REG0: rd_val = reg0;
			ttu_pkg::A_T3_REG1: rd_val = reg1;
			ttu_pkg::A_OUT_SEL: rd_val = outsel;
			ttu_pkg::A_SR_MASK01: rd_val = srm01;
			ttu_pkg::A_SR_MASK23: rd_val = srm23;
			ttu_pkg::A_STATUS: rd_val = {24'h000000, out_pin, 1'b0,
				run3, ctrl[ttu_pkg::RUN1], ctrl[ttu_pkg::RUN0]};
			default: rd_val = ttu_pkg::RST_VAL;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= ttu_pkg::RST_VAL;
			s_axi_rresp <= ttu_pkg::RESP_OKAY;
		end else if (s_axi_arvalid & s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_val;
			s_axi_rresp <= mapped(s_axi_araddr) ? ttu_pkg::RESP_OKAY :
				ttu_pkg::RESP_SLVERR;
		end else if (s_axi_rvalid & s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// plain configuration registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= ttu_pkg::RST_VAL;
			first_rel <= ttu_pkg::RST_VAL;
			second_rel <= ttu_pkg::RST_VAL;
			t3evt <= ttu_pkg::RST_VAL;
			outsel <= ttu_pkg::RST_VAL;
			srm01 <= ttu_pkg::RST_VAL;
			srm23 <= ttu_pkg::RST_VAL;
		end else if (wr_ok) begin
			case (aw_addr)
				ttu_pkg::A_CTRL: ctrl <= merge(ctrl, w_data, w_strb);
				ttu_pkg::A_FIRST_REL:
					first_rel <= merge(first_rel, w_data, w_strb);
				ttu_pkg::A_SECOND_REL:
					second_rel <= merge(second_rel, w_data, w_strb);
				ttu_pkg::A_T3_EVT: t3evt <= merge(t3evt, w_data, w_strb);
				ttu_pkg::A_OUT_SEL: outsel <= merge(outsel, w_data, w_strb);
				ttu_pkg::A_SR_MASK01: srm01 <= merge(srm01, w_data, w_strb);
				ttu_pkg::A_SR_MASK23: srm23 <= merge(srm23, w_data, w_strb);
				default: ;
			endcase
		end
	end

	// pins are synchronous; one stage gives the edges
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_d <= ttu_pkg::BYTE_ZERO;
			t3wrap_q <= 1'b0;
		end else begin
			pin_d <= in_pin;
			t3wrap_q <= t3_ovf | t3_unf;
		end
	end
	// first/second top-byte overflows appear as sources 6 and 7
	assign rise = {carry[7], carry[3], in_pin[5:0] & ~pin_d[5:0]};
	assign fall = {2'b00, ~in_pin[5:0] & pin_d[5:0]};

	// first/second timer count options; the third timer's wrap is taken
	// one cycle late so that no loop forms through the event logic
	// the wrap is an argument so that the assigns follow its changes
	function automatic logic csel(input logic [1:0] s, input logic run,
		input logic ck, input logic gate, input logic wrap);
		case (ttu_pkg::ttu_csrc_t'(s))
			ttu_pkg::CS_CLK: return run;
			ttu_pkg::CS_PIN: return run & ck;
			ttu_pkg::CS_T3: return run & wrap;
			ttu_pkg::CS_GATE: return run & gate;
			default: return 1'b0;
		endcase
	endfunction
	assign tick0 = csel(ctrl[ttu_pkg::SRC0_LO +: 2], ctrl[ttu_pkg::RUN0],
		rise[ttu_pkg::PIN_CLK0], in_pin[ttu_pkg::PIN_GATE0], t3wrap_q);
	assign tick1 = csel(ctrl[ttu_pkg::SRC1_LO +: 2], ctrl[ttu_pkg::RUN1],
		rise[ttu_pkg::PIN_CLK1], in_pin[ttu_pkg::PIN_GATE1], t3wrap_q);

	// a set chain bit hands a slice's carry to the next slice
	assign tick_v = ({ctrl[ttu_pkg::CHAIN_LO +: 7], 1'b0} & {carry[6:0], 1'b0})
		| (~{ctrl[ttu_pkg::CHAIN_LO +: 7], 1'b0}
		& {{4{tick1}}, {4{tick0}}});
	assign slice_ovf = carry & ~{1'b0, ctrl[ttu_pkg::CHAIN_LO +: 7]};
	assign load_v = {{4{wr_ok & (aw_addr == ttu_pkg::A_SECOND_CNT)}},
		{4{wr_ok & (aw_addr == ttu_pkg::A_FIRST_CNT)}}};
	assign ld_val = {merge(cnt_all[63:32], w_data, w_strb),
		merge(cnt_all[31:0], w_data, w_strb)};

	assign rel_all = {second_rel, first_rel};

	generate
		for (genvar g = 0; g < 8; g++) begin : g_slice
			ttu_slice u_slice (
				.aclk(aclk),
				.aresetn(aresetn),
				.tick(tick_v[g]),
				.load(load_v[g]),
				.load_val(ld_val[8*g +: 8]),
				.reload_val(rel_all[8*g +: 8]),
				.cnt(cnt_all[8*g +: 8]),
				.carry(carry[g])
			);
		end
	endgenerate

	// third timer event decode
	assign mode = ttu_pkg::ttu_mode_t'(t3ctrl[ttu_pkg::MODE_LO +: 2]);
	assign split = t3ctrl[ttu_pkg::SPLIT];
	assign run3 = t3ctrl[ttu_pkg::T3_RUN];
	assign ev_rel = pick(t3evt[ttu_pkg::EV_REL_LO +: 5], rise, fall);
	assign ev_cap = pick(t3evt[ttu_pkg::EV_CAP_LO +: 5], rise, fall);
	assign ev_start = pick(t3evt[ttu_pkg::EV_START_LO +: 5], rise, fall);
	assign ev_stop = pick(t3evt[ttu_pkg::EV_STOP_LO +: 5], rise, fall);
	assign ev_clr = pick(t3evt[ttu_pkg::EV_CLR_LO +: 5], rise, fall);
	assign hi_ev = pick(t3ctrl[ttu_pkg::HISRC_LO +: 5], rise, fall);
	// x4 decoding: a differs from b's old level when moving forward
	assign qdir = in_pin[ttu_pkg::PIN_QA] ^ pin_d[ttu_pkg::PIN_QB];

	always_comb begin
		case (mode)
			ttu_pkg::MD_TIMER: cnt_ev = 1'b1;
			ttu_pkg::MD_COUNT:
				cnt_ev = pick(t3evt[ttu_pkg::EV_CNT_LO +: 5], rise, fall);
			ttu_pkg::MD_QUAD: cnt_ev = |(in_pin[1:0] ^ pin_d[1:0]);
			default: cnt_ev = 1'b0;
		endcase
		if (mode == ttu_pkg::MD_QUAD) begin
			up = qdir;
		end else if (t3ctrl[ttu_pkg::DIR_EXT]) begin
			up = ~in_pin[t3ctrl[ttu_pkg::DIRSEL_LO +: 3]];
		end else begin
			up = ~t3ctrl[ttu_pkg::DIR_DOWN];
		end
	end

	assign tick_lo = run3 & cnt_ev;
	assign lo_wrap = tick_lo & (up ? t3cnt[15:0] == ttu_pkg::HALF_MAX :
		t3cnt[15:0] == ttu_pkg::HALF_ZERO);
	assign tick_hi = split ? run3 & hi_ev : lo_wrap;
	assign hi_wrap = tick_hi & (up ? t3cnt[31:16] == ttu_pkg::HALF_MAX :
		t3cnt[31:16] == ttu_pkg::HALF_ZERO);
	assign t3_ovf = hi_wrap & up;
	assign t3_unf = hi_wrap & ~up;
	// a wrap reloads from the first register unless it is capturing
	assign next_lo = (lo_wrap & ~t3ctrl[ttu_pkg::REG0_CAP]) ? reg0[15:0] :
		up ? t3cnt[15:0] + 16'h0001 : t3cnt[15:0] - 16'h0001;
	assign next_hi = (hi_wrap & ~t3ctrl[ttu_pkg::REG0_CAP]) ? reg0[31:16] :
		up ? t3cnt[31:16] + 16'h0001 : t3cnt[31:16] - 16'h0001;
	assign plain = ~(wr_ok & (aw_addr == ttu_pkg::A_T3_CNT)) & ~ev_clr
		& ~(ev_cap & t3ctrl[ttu_pkg::CAP_CLR])
		& ~(ev_rel & ~t3ctrl[ttu_pkg::REG1_CAP]);

	// software write wins over clear, then reload, then counting
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			t3cnt <= ttu_pkg::RST_VAL;
		end else if (wr_ok & (aw_addr == ttu_pkg::A_T3_CNT)) begin
			t3cnt <= merge(t3cnt, w_data, w_strb);
		end else if (ev_clr | (ev_cap & t3ctrl[ttu_pkg::CAP_CLR])) begin
			t3cnt <= ttu_pkg::RST_VAL;
		end else if (ev_rel & ~t3ctrl[ttu_pkg::REG1_CAP]) begin
			t3cnt <= reg1;
		end else begin
			if (tick_lo) begin
				t3cnt[15:0] <= next_lo;
			end
			if (tick_hi) begin
				t3cnt[31:16] <= next_hi;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			t3ctrl <= ttu_pkg::RST_VAL;
		end else if (wr_ok & (aw_addr == ttu_pkg::A_T3_CTRL)) begin
			t3ctrl <= merge(t3ctrl, w_data, w_strb);
		end else if (ev_stop) begin
			t3ctrl[ttu_pkg::T3_RUN] <= 1'b0;
		end else if (ev_start) begin
			t3ctrl[ttu_pkg::T3_RUN] <= 1'b1;
		end else if (t3ctrl[ttu_pkg::ONE_SHOT] & hi_wrap) begin
			t3ctrl[ttu_pkg::T3_RUN] <= 1'b0;
		end
	end

	// each register is a reload source or a capture target
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			reg0 <= ttu_pkg::RST_VAL;
			reg1 <= ttu_pkg::RST_VAL;
		end else begin
			if (wr_ok & (aw_addr == ttu_pkg::A_T3_REG0)) begin
				reg0 <= merge(reg0, w_data, w_strb);
			end else if (ev_cap & t3ctrl[ttu_pkg::REG0_CAP]) begin
				reg0 <= t3cnt;
			end
			if (wr_ok & (aw_addr == ttu_pkg::A_T3_REG1)) begin
				reg1 <= merge(reg1, w_data, w_strb);
			end else if (ev_cap & t3ctrl[ttu_pkg::REG1_CAP]) begin
				reg1 <= t3cnt;
			end
		end
	end

	assign ev = {lo_wrap & split, ev_cap, t3_unf, t3_ovf, slice_ovf};
	assign ev16 = {4'h0, ev};

	// outputs toggle on a chosen event; nodes pulse on any masked one
	generate
		for (genvar k = 0; k < 4; k++) begin : g_out
			logic [3:0] sel;
			logic [11:0] msk;
			assign sel = outsel[ttu_pkg::SEL_W*k +: ttu_pkg::SEL_W];
			assign msk = k < 2 ? srm01[ttu_pkg::SR_STRIDE*(k%2) +: 12] :
				srm23[ttu_pkg::SR_STRIDE*(k%2) +: 12];
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					out_pin[k] <= 1'b0;
					srq[k] <= 1'b0;
				end else begin
					if (sel != 4'h0 && ev16[sel - 4'h1]) begin
						out_pin[k] <= ~out_pin[k];
					end
					srq[k] <= |(ev & msk);
				end
			end
		end
	endgenerate

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	first_reload_a: assert property (tick_v[0] && carry[3]
		&& (&ctrl[ttu_pkg::CHAIN_LO +: 3]) && !load_v[0]
		|=> cnt_all[31:0] == $past(first_rel))
		else $error("first timer did not reload on overflow");
	// a full slice reloads, which may leave it at its old value
	chain64_a: assert property (carry[3]
		&& ctrl[ttu_pkg::CHAIN_LO + 3] && !load_v[4]
		|=> cnt_all[39:32] == ($past(cnt_all[39:32]) == 8'hff ?
		$past(second_rel[7:0]) : $past(cnt_all[39:32]) + 8'h01))
		else $error("second timer ignored chained carry");
	t3_wrap_a: assert property (hi_wrap && !split && plain
		&& !t3ctrl[ttu_pkg::REG0_CAP] |=> t3cnt == $past(reg0))
		else $error("third timer did not reload on wrap");
	t3_extrel_a: assert property (ev_rel
		&& !t3ctrl[ttu_pkg::REG1_CAP]
		&& !ev_clr && !(ev_cap && t3ctrl[ttu_pkg::CAP_CLR])
		&& !(wr_ok && aw_addr == ttu_pkg::A_T3_CNT)
		|=> t3cnt == $past(reg1))
		else $error("third timer missed event reload");
	t3_capture_a: assert property (ev_cap
		&& t3ctrl[ttu_pkg::REG0_CAP]
		&& !(wr_ok && aw_addr == ttu_pkg::A_T3_REG0)
		|=> reg0 == $past(t3cnt))
		else $error("capture register not loaded");
	cap_clear_a: assert property (ev_cap
		&& t3ctrl[ttu_pkg::CAP_CLR]
		&& !(wr_ok && aw_addr == ttu_pkg::A_T3_CNT)
		|=> t3cnt == ttu_pkg::RST_VAL)
		else $error("capture and clear left a count");
	t3_down_a: assert property (run3 && !split
		&& mode == ttu_pkg::MD_TIMER
		&& t3ctrl[ttu_pkg::DIR_DOWN] && !t3ctrl[ttu_pkg::DIR_EXT]
		&& plain && t3cnt[15:0] != ttu_pkg::HALF_ZERO
		|=> t3cnt == $past(t3cnt) - 32'h1)
		else $error("third timer failed to count down");
	// only a start event or a software write may restart it next
	one_shot_a: assert property (hi_wrap
		&& t3ctrl[ttu_pkg::ONE_SHOT] && !ev_start
		&& !(wr_ok && aw_addr == ttu_pkg::A_T3_CTRL)
		|=> !run3 ##1 (!run3 || $past(ev_start || wr_ok)))
		else $error("one-shot timer kept running");
	srq_route_a: assert property (|(ev & srm01[11:0]) |=> srq[0])
		else $error("service request node 0 missed event");
	out_toggle_a: assert property (outsel[3:0] != 4'h0
		&& ev16[outsel[3:0] - 4'h1] |=> out_pin[0] != $past(out_pin[0]))
		else $error("output pin 0 did not toggle");
	reset_clear_a: assert property (@(posedge aclk)
		disable iff (1'b0)
		!aresetn |=> t3cnt == ttu_pkg::RST_VAL && !run3
		&& ctrl == ttu_pkg::RST_VAL)
		else $error("reset left a timer active");

	quad_cnt_c: cover property (run3 && mode == ttu_pkg::MD_QUAD && cnt_ev);
	split_c: cover property (split && lo_wrap ##1 tick_hi);
	cascade_c: cover property (carry[3] && ctrl[ttu_pkg::CHAIN_LO + 3]);
	capture_c: cover property (ev_cap && t3ctrl[ttu_pkg::CAP_CLR]);
endmodule

/* testbench/ttu_pins.sv */
// far-side model: drives the event pins and counts service requests
`timescale 1ns/1ps
module ttu_pins (
	input wire logic aclk,
	input wire logic [3:0] srq,
	output logic [7:0] in_pin
);
	int srq_n [4];
	initial begin
		in_pin = 8'h00;
		srq_n = '{default: 0};
	end
	// a request stands one cycle per event, so high cycles are counted
	always @(posedge aclk) begin
		for (int k = 0; k < 4; k++) begin
			if (srq[k] === 1'b1) srq_n[k]++;
		end
	end
	// each level holds two samples so that the edge is always seen
	task automatic set_pins(input logic [7:0] m, input logic v);
		@(posedge aclk);
		in_pin <= v ? (in_pin | m) : (in_pin & ~m);
		repeat (2) @(posedge aclk);
	endtask
	task automatic pulse(input logic [7:0] m, input int n);
		repeat (n) begin
			set_pins(m, 1'b1);
			set_pins(m, 1'b0);
		end
	endtask
endmodule

/* testbench/tb_top.sv */
// self-checking bench of the triple timer/counter unit
`timescale 1ns/1ps
module tb_top;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [31:0] s_axi_rdata, d, r0, cv;
	logic [7:0] in_pin;
	logic [3:0] out_pin, srq;
	logic [63:0] c, r, e;
	logic [6:0] ch;
	int errors, comparisons, seed, n;
	ttu_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .in_pin, .out_pin, .srq);
	ttu_pins pins (.aclk, .srq, .in_pin);
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	task automatic end_of_test();
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic fail(string m);
		errors++;
		$display("[FAIL] %0t %s", $time, m);
	endtask
	task automatic chk(logic [31:0] g, logic [31:0] x);
		comparisons++;
		if (g !== x) fail($sformatf("value %h expected %h", g, x));
	endtask
	task automatic chk_resp(logic [1:0] g, logic [1:0] x);
		comparisons++;
		if (g !== x) fail($sformatf("response %h expected %h", g, x));
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] v);
		int i;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (i == 100) begin
			fail("write timeout");
			end_of_test();
		end
	endtask
	task automatic rd(logic [7:0] a);
		int i;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		d = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (i == 100) begin
			fail("read timeout");
			end_of_test();
		end
	endtask
	// one pin tick of both wide timers; slice i rides on slice i-1 when chained
	function automatic logic [63:0] step(logic [63:0] v, logic [63:0] rl,
		logic [6:0] cb);
		logic cy;
		logic tk;
		cy = 1'b0;
		for (int i = 0; i < 8; i++) begin
			tk = (i == 0) ? 1'b1 : (cb[i-1] ? cy : 1'b1);
			cy = tk && v[i*8+:8] == 8'hff;
			if (tk) v[i*8+:8] = cy ? rl[i*8+:8] : v[i*8+:8] + 8'h01;
		end
		return v;
	endfunction
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hf;
		errors = 0;
		comparisons = 0;
		seed = 35;
		aresetn = 1'b0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		for (int a = 0; a <= 8'h34; a += 4) begin
			rd(8'(a));
			chk(d, ttu_pkg::RST_VAL);
		end
		rd(8'h38);
		chk_resp(rs, ttu_pkg::RESP_SLVERR);
		wr(ttu_pkg::A_STATUS, ttu_pkg::ALL_ONES);
		chk_resp(rs, ttu_pkg::RESP_SLVERR);
		// 32-bit first timer wraps into its reload, toggles a pin, requests
		r0 = $random(seed) & 32'h7f7f_7f7f; // no byte wraps on two ticks
		wr(ttu_pkg::A_FIRST_REL, r0);
		wr(ttu_pkg::A_FIRST_CNT, ttu_pkg::ALL_ONES);
		wr(ttu_pkg::A_OUT_SEL, 32'h0000_0004);
		wr(ttu_pkg::A_SR_MASK01, 32'h0000_0008);
		wr(ttu_pkg::A_CTRL, 32'h0000_021d);
		pins.pulse(8'h04, 1);
		rd(ttu_pkg::A_FIRST_CNT);
		chk(d, r0);
		chk({28'h0, out_pin}, 32'h1);
		chk(pins.srq_n[0], 32'h1);
		pins.pulse(8'h04, 2);
		rd(ttu_pkg::A_FIRST_CNT);
		chk(d, r0 + 32'h2);
		// random split and join patterns of both timers
		repeat (8) begin
			ch = 7'($random(seed));
			c = {$random(seed), $random(seed)};
			r = {$random(seed), $random(seed)};
			n = $random(seed);
			for (int b = 0; b < 8; b++) if (n[b]) c[b*8+:8] = 8'hff;
			n = 1 + ($random(seed) & 3);
			wr(ttu_pkg::A_CTRL, ttu_pkg::RST_VAL);
			wr(ttu_pkg::A_FIRST_CNT, c[31:0]);
			wr(ttu_pkg::A_SECOND_CNT, c[63:32]);
			wr(ttu_pkg::A_FIRST_REL, r[31:0]);
			wr(ttu_pkg::A_SECOND_REL, r[63:32]);
			wr(ttu_pkg::A_CTRL, 32'h0a03 | {23'h0, ch, 2'h0});
			pins.pulse(8'h14, n);
			e = c;
			repeat (n) e = step(e, r, ch);
			rd(ttu_pkg::A_FIRST_CNT);
			chk(d, e[31:0]);
			rd(ttu_pkg::A_SECOND_CNT);
			chk(d, e[63:32]);
		end
		// third timer as counter on pin 0 rising: up, down, pin direction
		r0 = $random(seed);
		wr(ttu_pkg::A_T3_REG0, r0);
		wr(ttu_pkg::A_T3_EVT, 32'h8);
		wr(ttu_pkg::A_T3_CNT, 32'hffff_fffe);
		wr(ttu_pkg::A_T3_CTRL, 32'h3);
		pins.pulse(8'h01, 2);
		rd(ttu_pkg::A_T3_CNT);
		chk(d, r0);
		wr(ttu_pkg::A_T3_CNT, 32'h1);
		wr(ttu_pkg::A_T3_CTRL, 32'hb);
		pins.pulse(8'h01, 2);
		rd(ttu_pkg::A_T3_CNT);
		chk(d, r0);
		wr(ttu_pkg::A_T3_CNT, 32'ha);
		wr(ttu_pkg::A_T3_CTRL, 32'h1813);
		pins.set_pins(8'h40, 1'b1);
		pins.pulse(8'h01, 1);
		rd(ttu_pkg::A_T3_CNT);
		chk(d, 32'h9);
		// capture on every edge choice of pin 1, then capture and clear
		wr(ttu_pkg::A_T3_CTRL, 32'h103);
		for (int k = 1; k <= 3; k++) begin
			wr(ttu_pkg::A_T3_EVT, 32'h8 | ((k * 8 + 1) << 10));
			wr(ttu_pkg::A_T3_REG1, ttu_pkg::RST_VAL);
			cv = $random(seed);
			wr(ttu_pkg::A_T3_CNT, cv);
			pins.set_pins(8'h02, 1'b1);
			rd(ttu_pkg::A_T3_REG1);
			r0 = k[0] ? cv : 32'h0;
			chk(d, r0);
			wr(ttu_pkg::A_T3_CNT, ~cv);
			pins.set_pins(8'h02, 1'b0);
			rd(ttu_pkg::A_T3_REG1);
			chk(d, k[1] ? ~cv : r0);
		end
		wr(ttu_pkg::A_T3_CTRL, 32'h303);
		pins.pulse(8'h02, 1);
		rd(ttu_pkg::A_T3_CNT);
		chk(d, ttu_pkg::RST_VAL);
		// reload from register 1 on a falling edge of pin 3
		wr(ttu_pkg::A_T3_CTRL, 32'h3);
		wr(ttu_pkg::A_T3_EVT, 32'h8 | (32'h13 << 5));
		r0 = $random(seed);
		wr(ttu_pkg::A_T3_REG1, r0);
		wr(ttu_pkg::A_T3_CNT, 32'h55);
		pins.set_pins(8'h08, 1'b1);
		rd(ttu_pkg::A_T3_CNT);
		chk(d, 32'h55);
		pins.set_pins(8'h08, 1'b0);
		rd(ttu_pkg::A_T3_CNT);
		chk(d, r0);
		// quadrature: A leading B counts up four, B leading counts down
		wr(ttu_pkg::A_T3_CTRL, 32'h5);
		wr(ttu_pkg::A_T3_CNT, 32'h64);
		pins.set_pins(8'h01, 1'b1);
		pins.set_pins(8'h02, 1'b1);
		pins.set_pins(8'h01, 1'b0);
		pins.set_pins(8'h02, 1'b0);
		rd(ttu_pkg::A_T3_CNT);
		chk(d, 32'h68);
		pins.set_pins(8'h02, 1'b1);
		pins.set_pins(8'h01, 1'b1);
		pins.set_pins(8'h02, 1'b0);
		pins.set_pins(8'h01, 1'b0);
		rd(ttu_pkg::A_T3_CNT);
		chk(d, 32'h64);
		// split halves: the lower wraps alone, the upper counts pin 1
		wr(ttu_pkg::A_T3_REG0, 32'h10);
		wr(ttu_pkg::A_T3_CNT, 32'h0005_ffff);
		wr(ttu_pkg::A_T3_CTRL, 32'h1_2043);
		pins.pulse(8'h01, 1);
		pins.pulse(8'h02, 1);
		rd(ttu_pkg::A_T3_CNT);
		chk(d, 32'h0006_0010);
		// pin 5 starts and stops a one-shot third timer whose wrap
		// clocks the first timer, toggles pin 1 and requests node 1
		wr(ttu_pkg::A_CTRL, 32'h0000_0401);
		wr(ttu_pkg::A_FIRST_CNT, ttu_pkg::RST_VAL);
		wr(ttu_pkg::A_OUT_SEL, 32'h0000_0094);
		wr(ttu_pkg::A_SR_MASK01, 32'h0100_0008);
		wr(ttu_pkg::A_T3_EVT, 32'h0156_8008);
		wr(ttu_pkg::A_T3_CTRL, 32'h22);
		wr(ttu_pkg::A_T3_CNT, ttu_pkg::ALL_ONES);
		pins.pulse(8'h01, 1);
		rd(ttu_pkg::A_T3_CNT);
		chk(d, ttu_pkg::ALL_ONES);
		pins.set_pins(8'h20, 1'b1);
		pins.pulse(8'h01, 2);
		rd(ttu_pkg::A_T3_CNT);
		chk(d, 32'h10);
		rd(ttu_pkg::A_FIRST_CNT);
		chk(d, 32'h0101_0101);
		chk({31'h0, out_pin[1]}, 32'h1);
		chk(pins.srq_n[1], 32'h1);
		wr(ttu_pkg::A_T3_CTRL, 32'h2);
		pins.set_pins(8'h20, 1'b0);
		pins.set_pins(8'h20, 1'b1);
		pins.pulse(8'h01, 1);
		pins.set_pins(8'h20, 1'b0);
		pins.pulse(8'h01, 1);
		rd(ttu_pkg::A_T3_CNT);
		chk(d, 32'h11);
		end_of_test();
	end
endmodule
